//--- shared/dcd_pkg.sv
package dcd_pkg;
  localparam logic [7:0] ALT_START_VALUE  = 8'hff;
  localparam logic [3:0] RETRY_INDEX_ON   = 4'd10;
  localparam logic [3:0] RETRY_INDEX_OFF  = 4'd2;
  localparam logic [2:0] EXT_BYTES_SHORT  = 3'd4;
  localparam logic [2:0] EXT_BYTES_LONG   = 3'd7;
  localparam logic [4:0] SPAN_4_NARROW    = 5'd5;
  localparam logic [4:0] SPAN_4_WIDE      = 5'd11;
  localparam logic [4:0] SPAN_7_NARROW    = 5'd11;
  localparam logic [4:0] SPAN_7_WIDE      = 5'd22;
  localparam logic [2:0] HEAD_BITS_NARROW = 3'd3;
  localparam logic [2:0] HEAD_BITS_WIDE   = 3'd4;
  localparam logic [8:0] FULL_TRACK_COUNT = 9'd256;
  localparam logic [11:0] SIZE_CODE0      = 12'd256;
  localparam logic [11:0] SIZE_CODE1      = 12'd512;
  localparam logic [11:0] SIZE_CODE2      = 12'd1024;
  localparam logic [11:0] SIZE_CODE3      = 12'd128;
  localparam int          FIFO_DEPTH      = 8;
  localparam int          FIFO_WIDTH      = 8;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_READ_SECTOR, CMD_WRITE_SECTOR, CMD_READ_NEXT, CMD_SCAN_ID,
    CMD_WRITE_ID, CMD_FORMAT_TRACK, CMD_FORMAT_SECTOR, CMD_COMPUTE_CORR,
    CMD_SET_PARAM, CMD_LOAD_PARAM, CMD_SLEEP, CMD_DUMP
  } dcd_cmd_type;

  typedef struct packed {
    logic [15:0] cylinder;
    logic [3:0]  head;
    logic [7:0]  sector;
    logic        bad_block;
    logic        relocation;
    logic        crc_ok;
  } dcd_id_type;

  typedef struct packed {
    logic multi;
    logic long_mode;
    logic no_retry;
    logic sector_from_buffer;
    logic id_offset;
    logic pulse_mark;
    logic gap_gate_off;
    logic skip_pattern;
    logic dump_single;
    logic dump_ones_sync;
  } dcd_opt_type;

  typedef struct packed {
    logic       nrz;
    logic       relocate;
    logic       ecc7;
    logic       head4;
    logic       span_wide;
    logic       hard_sector;
    logic       mfm_nrz_iface;
    logic       user_size;
    logic [11:0] sector_size;
  } dcd_param_type;

  typedef struct packed {
    logic not_ready;
    logic write_fault;
    logic aborted;
    logic id_not_found;
    logic bad_block;
    logic reloc_found;
    logic data_check;
    logic mark_missing;
  } dcd_err_type;
endpackage : dcd_pkg

//--- hw/dcd_read_sector.sv
`timescale 1ns/10ps
// Functional notes
// - twelve commands; host may only issue read, write, format, set parameter
// - decode read/write sector, read next, scan, write id, format codes
// - decode compute correction, sleep, load parameter block, dump, set parameter
// - single sector ignores count; multi reads consecutive, count zero means 256
// - long option: no check, move 4 or 7 extra bytes after data
// - id search retries 10 or 2 index pulses; no data retry or correction
// - write sector target from sector register or first buffer byte
// - write id placement option and mark enable pulse option
// - format gate option keeps write gate on or drops it in gaps
// - compute correction always moves syndrome; pattern option skips pattern
// - encoding option mfm/rll or nrz; interface option rll default or mfm/nrz
// - ecc length option picks 4 or 7 byte ecc and extension
// - head width option picks 3 or 4 head select bits
// - span option: 5/11 bits narrow, 11/22 bits wide
// - sectoring option soft default or hard; run input becomes sector pulse
// - size option copies cylinder registers into sector size register
// - dump field count option and sync byte/crc preset option
// - bad block ends command; relocation id loads task registers, sets flag
// - ignore sector number compares only cylinder and head
// - start writes ff to alternate sector; abort on not ready or fault
// - buffer and micro requests, wait buffer ready, micro clears request
// - per sector update alternate, count down in multi mode only, then done bit and interrupt

module dcd_fifo
  import dcd_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;
  assign in_ready  = count_reg != DEPTH[AW:0];
  assign out_valid = count_reg != '0;
  assign out_data  = mem_reg[rd_ptr_reg];
  always_ff @(posedge core_clk) begin
    if (push) mem_reg[wr_ptr_reg] <= in_data;
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dcd_fifo

module dcd_read_sector
  import dcd_pkg::*;
(
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset,
  // command entry
  input  wire logic [7:0]    command_byte,
  input  wire logic          command_strobe,
  input  wire logic          command_from_host,
  output logic               command_refused,
  output dcd_cmd_type        command_kind,
  output logic               command_start,
  output dcd_opt_type        options,
  output dcd_param_type      params,
  output logic [2:0]         ext_bytes,
  output logic [2:0]         head_select_bits,
  output logic [4:0]         correction_span,
  output logic               sector_pulse_mode,
  // task file values
  input  wire logic [7:0]    sector_number_in,
  input  wire logic [7:0]    sector_count_in,
  input  wire logic [15:0]   cylinder_in,
  input  wire logic [3:0]    head_in,
  input  wire logic [1:0]    size_code_in,
  input  wire logic          ignore_sector_number,
  input  wire logic          disk_request_disable,
  output logic [7:0]         sector_number,
  output logic [8:0]         sector_count,
  output logic [7:0]         alt_sector_number,
  output dcd_err_type        errors,
  output logic [7:0]         reloc_bad_sector,
  output logic [7:0]         reloc_sector,
  output logic [15:0]        reloc_cylinder,
  output logic [3:0]         reloc_head,
  output logic               relocation_found_flag,
  // drive side
  input  wire logic          drive_ready,
  input  wire logic          drive_write_fault,
  input  wire logic          index_pulse,
  input  wire logic          id_valid,
  input  wire dcd_id_type    id_field,
  input  wire logic          data_field_mark,
  input  wire logic          data_mark_missing,
  input  wire logic          disk_byte_valid,
  input  wire logic [7:0]    disk_byte,
  input  wire logic          data_check_done,
  input  wire logic          data_check_error,
  output logic               disk_data_ready,
  output logic               check_enable,
  output logic               read_gate_out,
  // buffer manager and microcontroller
  input  wire logic          buffer_ready_in,
  input  wire logic          clear_request_interrupt,
  input  wire logic          clear_command_done,
  input  wire logic          buffer_write_ready,
  output logic               buffer_write_valid,
  output logic [7:0]         buffer_write_data,
  output logic               buffer_request_out,
  output logic               micro_request_interrupt,
  output logic               disk_command_done,
  output logic               micro_interrupt_out
);
  typedef enum logic [9:0] {
    ST_IDLE   = 10'b00_0000_0001,
    ST_PREP   = 10'b00_0000_0010,
    ST_REQ    = 10'b00_0000_0100,
    ST_SEARCH = 10'b00_0000_1000,
    ST_RELOC  = 10'b00_0001_0000,
    ST_MARK   = 10'b00_0010_0000,
    ST_DATA   = 10'b00_0100_0000,
    ST_CHECK  = 10'b00_1000_0000,
    ST_NEXT   = 10'b01_0000_0000,
    ST_DONE   = 10'b10_0000_0000
  } dcd_state_type;

  dcd_state_type state_reg;
  dcd_state_type state_next;
  logic [3:0]    index_count_reg;
  logic [11:0]   byte_count_reg;
  logic          in_ext_reg;

  // command decode
  wire [7:0] c = command_byte;
  wire fmt_tail = c[3:2] == 2'b00 && c[0];
  wire is_rd  = c[7:3] == 5'b00100;
  wire is_wr  = c[7:4] == 4'b0011;
  wire is_rn  = c[7:4] == 4'b0110 && fmt_tail;
  wire is_sc  = c[7:4] == 4'b0100 && c[3:1] == 3'b000;
  wire is_wi  = c[7:4] == 4'b1011 && !c[2];
  wire is_ft  = c[7:4] == 4'b0101 && fmt_tail;
  wire is_fs  = c[7:4] == 4'b1101 && fmt_tail;
  wire is_cc  = c[7:3] == 5'b00001 && c[1:0] == 2'b00;
  wire is_sl  = c == 8'h98;
  wire is_lp  = c[7:3] == 5'b10001;
  wire is_dm  = c[7:4] == 4'b1010 && c[0];
  wire is_sp  = !c[6] && !c[5] && !c[3];
  wire dcd_cmd_type kind = is_rd ? CMD_READ_SECTOR : is_wr ? CMD_WRITE_SECTOR :
                           is_rn ? CMD_READ_NEXT : is_sc ? CMD_SCAN_ID :
                           is_wi ? CMD_WRITE_ID : is_ft ? CMD_FORMAT_TRACK :
                           is_fs ? CMD_FORMAT_SECTOR : is_cc ? CMD_COMPUTE_CORR :
                           is_sl ? CMD_SLEEP : is_lp ? CMD_LOAD_PARAM :
                           is_dm ? CMD_DUMP : is_sp ? CMD_SET_PARAM : CMD_NONE;
  wire host_ok = kind == CMD_READ_SECTOR || kind == CMD_WRITE_SECTOR ||
                 kind == CMD_FORMAT_TRACK || kind == CMD_FORMAT_SECTOR ||
                 kind == CMD_SET_PARAM;
  wire busy    = state_reg != ST_IDLE;
  wire accept  = command_strobe && kind != CMD_NONE && !busy &&
                 (!command_from_host || host_ok);
  wire refuse  = command_strobe && !accept;

  wire dcd_opt_type opt_in = '{
    multi:              c[2],
    long_mode:          c[1],
    no_retry:           c[0],
    sector_from_buffer: is_wr & c[3],
    id_offset:          is_wi & c[3],
    pulse_mark:         is_wi & c[1],
    gap_gate_off:       (is_ft | is_fs) & c[1],
    skip_pattern:       is_cc & c[2],
    dump_single:        is_dm & c[3],
    dump_ones_sync:     is_dm & c[2]
  };
  wire [11:0] std_size = size_code_in == 2'd0 ? SIZE_CODE0 :
                         size_code_in == 2'd1 ? SIZE_CODE1 :
                         size_code_in == 2'd2 ? SIZE_CODE2 : SIZE_CODE3;
  wire [11:0] size_now = params.user_size ? params.sector_size : std_size;

  // read sector tests
  wire id_match = id_field.cylinder == cylinder_in && id_field.head == head_in &&
                  (ignore_sector_number || id_field.sector == sector_number) &&
                  id_field.crc_ok;
  wire [3:0] retry_limit = options.no_retry ? RETRY_INDEX_OFF : RETRY_INDEX_ON;
  wire search_out = index_pulse && index_count_reg + 4'd1 >= retry_limit;
  wire byte_take  = disk_byte_valid && disk_data_ready;
  wire [11:0] field_len = in_ext_reg ? {9'd0, ext_bytes} : size_now;
  wire last_byte  = byte_take && byte_count_reg + 12'd1 == field_len;
  wire abort_now  = !drive_ready || drive_write_fault;
  wire count_last = !options.multi || sector_count == 9'd1;
  wire enter_req  = state_next == ST_REQ && state_reg != ST_REQ;
  wire fifo_in_ready;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:   if (accept && kind == CMD_READ_SECTOR) state_next = ST_PREP;
      ST_PREP:   state_next = abort_now ? ST_DONE : ST_REQ;
      ST_REQ:    if (disk_request_disable || buffer_ready_in) state_next = ST_SEARCH;
      ST_SEARCH: begin
        if (id_valid && id_match)
          state_next = id_field.bad_block ? (params.relocate ? ST_RELOC : ST_DONE)
                                          : ST_MARK;
        else if (search_out) state_next = ST_DONE;
      end
      ST_RELOC:  if (id_valid || index_pulse) state_next = ST_DONE;
      ST_MARK:   begin
        if (data_field_mark) state_next = ST_DATA;
        else if (data_mark_missing) state_next = ST_DONE;
      end
      ST_DATA:   begin
        if (last_byte && (in_ext_reg || !options.long_mode))
          state_next = options.long_mode ? ST_NEXT : ST_CHECK;
      end
      ST_CHECK:  if (data_check_done) state_next = data_check_error ? ST_DONE : ST_NEXT;
      ST_NEXT:   state_next = count_last ? ST_DONE : ST_REQ;
      ST_DONE:   state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) state_reg <= ST_IDLE;
    else       state_reg <= state_next;
  end

  // decoder outputs and parameter store
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      command_refused <= 1'b0;
      command_start   <= 1'b0;
      command_kind    <= CMD_NONE;
      options         <= '0;
      params          <= '0;
    end else begin
      command_refused <= refuse;
      command_start   <= accept;
      if (accept) begin
        command_kind <= kind;
        options      <= opt_in;
      end
      if (accept && kind == CMD_SET_PARAM) begin
        params.nrz       <= c[7] & params.mfm_nrz_iface;
        params.relocate  <= c[4];
        params.ecc7      <= c[2];
        params.head4     <= c[1];
        params.span_wide <= c[0];
      end
      if (accept && kind == CMD_LOAD_PARAM) begin
        params.hard_sector   <= c[2];
        params.mfm_nrz_iface <= c[1];
        params.user_size     <= c[0];
        if (!c[1]) params.nrz <= 1'b0;
        if (c[0]) params.sector_size <= cylinder_in[11:0];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ext_bytes         <= EXT_BYTES_SHORT;
      head_select_bits  <= HEAD_BITS_NARROW;
      correction_span   <= SPAN_4_NARROW;
      sector_pulse_mode <= 1'b0;
    end else begin
      ext_bytes         <= params.ecc7 ? EXT_BYTES_LONG : EXT_BYTES_SHORT;
      head_select_bits  <= params.head4 ? HEAD_BITS_WIDE : HEAD_BITS_NARROW;
      correction_span   <= params.ecc7 ? (params.span_wide ? SPAN_7_WIDE : SPAN_7_NARROW)
                                       : (params.span_wide ? SPAN_4_WIDE : SPAN_4_NARROW);
      sector_pulse_mode <= params.hard_sector;
    end
  end

  // read sector data path counters
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      index_count_reg <= '0;
      byte_count_reg  <= '0;
      in_ext_reg      <= 1'b0;
    end else begin
      if (state_reg != ST_SEARCH) index_count_reg <= '0;
      else if (index_pulse)       index_count_reg <= index_count_reg + 4'd1;
      if (state_reg != ST_DATA || last_byte) byte_count_reg <= '0;
      else if (byte_take)         byte_count_reg <= byte_count_reg + 12'd1;
      if (state_reg != ST_DATA)   in_ext_reg <= 1'b0;
      else if (last_byte && options.long_mode) in_ext_reg <= 1'b1;
    end
  end

  // task registers and errors
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sector_number         <= '0;
      sector_count          <= '0;
      alt_sector_number     <= '0;
      errors                <= '0;
      reloc_bad_sector      <= '0;
      reloc_sector          <= '0;
      reloc_cylinder        <= '0;
      reloc_head            <= '0;
      relocation_found_flag <= 1'b0;
    end else begin
      if (state_reg == ST_IDLE && state_next == ST_PREP) begin
        sector_number         <= sector_number_in;
        sector_count          <= sector_count_in == 8'd0 ? FULL_TRACK_COUNT
                                                         : {1'b0, sector_count_in};
        alt_sector_number     <= ALT_START_VALUE;
        errors                <= '0;
        relocation_found_flag <= 1'b0;
      end
      if (state_reg == ST_PREP && abort_now) begin
        errors.not_ready   <= !drive_ready;
        errors.write_fault <= drive_write_fault;
        errors.aborted     <= 1'b1;
      end
      if (state_reg == ST_SEARCH && !(id_valid && id_match) && search_out)
        errors.id_not_found <= 1'b1;
      if (state_reg == ST_SEARCH && id_valid && id_match && id_field.bad_block) begin
        errors.bad_block <= 1'b1;
        reloc_bad_sector <= id_field.sector;
      end
      if (state_reg == ST_RELOC && id_valid && id_field.relocation) begin
        relocation_found_flag <= 1'b1;
        errors.reloc_found    <= 1'b1;
        reloc_sector          <= id_field.sector;
        reloc_cylinder        <= id_field.cylinder;
        reloc_head            <= id_field.head;
      end
      if (state_reg == ST_MARK && !data_field_mark && data_mark_missing)
        errors.mark_missing <= 1'b1;
      if (state_reg == ST_CHECK && data_check_done && data_check_error)
        errors.data_check <= 1'b1;
      if (state_reg == ST_NEXT) begin
        alt_sector_number <= sector_number;
        if (options.multi) begin
          sector_count  <= sector_count - 9'd1;
          sector_number <= sector_number + 8'd1;
        end
      end
    end
  end

  // handshakes and completion
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      buffer_request_out      <= 1'b0;
      micro_request_interrupt <= 1'b0;
      disk_command_done       <= 1'b0;
      micro_interrupt_out     <= 1'b0;
      check_enable            <= 1'b0;
      read_gate_out           <= 1'b0;
      disk_data_ready         <= 1'b0;
    end else begin
      if (enter_req && !disk_request_disable) buffer_request_out <= 1'b1;
      else if (buffer_ready_in)               buffer_request_out <= 1'b0;
      if (enter_req && !disk_request_disable) micro_request_interrupt <= 1'b1;
      else if (clear_request_interrupt)       micro_request_interrupt <= 1'b0;
      if (state_reg == ST_DONE)       disk_command_done <= 1'b1;
      else if (clear_command_done)    disk_command_done <= 1'b0;
      if (state_reg == ST_DONE)       micro_interrupt_out <= 1'b1;
      else if (clear_command_done)    micro_interrupt_out <= 1'b0;
      check_enable    <= !options.long_mode &&
                         (state_next == ST_DATA || state_next == ST_CHECK);
      read_gate_out   <= state_next == ST_SEARCH || state_next == ST_RELOC ||
                         state_next == ST_MARK || state_next == ST_DATA;
      // a take with no drain may use the last free slot
      disk_data_ready <= state_next == ST_DATA && fifo_in_ready &&
                         (!byte_take || (buffer_write_valid && buffer_write_ready));
    end
  end

  dcd_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) data_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (byte_take),
    .in_ready  (fifo_in_ready),
    .in_data   (disk_byte),
    .out_valid (buffer_write_valid),
    .out_ready (buffer_write_ready),
    .out_data  (buffer_write_data)
  );
endmodule : dcd_read_sector

//--- verif/dcd_props.sv
`timescale 1ns/10ps
module dcd_props
  import dcd_pkg::*;
(
  // clock and reset
  input wire logic core_clk, reset,
  // command entry
  input wire logic [7:0] command_byte,
  input wire logic command_strobe, command_from_host, command_refused, command_start,
  input wire dcd_cmd_type command_kind,
  input wire dcd_opt_type options,
  input wire dcd_param_type params,
  input wire logic [2:0] ext_bytes, head_select_bits,
  input wire logic [4:0] correction_span,
  // read sector flow
  input wire logic [7:0] alt_sector_number,
  input wire logic check_enable, buffer_request_out, micro_request_interrupt, buffer_ready_in,
  input wire logic disk_command_done, micro_interrupt_out, clear_command_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_host_bad;
    command_strobe && command_from_host && (command_byte[6:5] == 2'b11
      || command_byte[7:4] inside {4'h4, 4'ha, 4'hb} || command_byte[6:5] == 2'b00 && command_byte[3]);
  endsequence
  sequence s_read_go;
    command_start && command_kind == CMD_READ_SECTOR;
  endsequence
  host_refuse_a: assert property (s_host_bad |=> command_refused && !command_start)
    else $error("host issued a micro-only command and it was accepted");
  read_opts_a: assert property (s_read_go |-> options.multi == $past(command_byte[2])
    && options.long_mode == $past(command_byte[1]) && options.no_retry == $past(command_byte[0]))
    else $error("read options differ from the command byte");
  ext_len_a: assert property (ext_bytes == ($past(params.ecc7) ? 3'd7 : 3'd4))
    else $error("extension length wrong");
  head_bits_a: assert property (head_select_bits == ($past(params.head4) ? 3'd4 : 3'd3))
    else $error("head select width wrong");
  span_sel_a: assert property (correction_span == ($past(params.ecc7) ?
    ($past(params.span_wide) ? 5'd22 : 5'd11) : ($past(params.span_wide) ? 5'd11 : 5'd5)))
    else $error("correction span wrong");
  alt_start_a: assert property (s_read_go |-> ##[0:1] alt_sector_number == 8'hff)
    else $error("alternate sector not preset");
  check_off_a: assert property (check_enable |-> !options.long_mode)
    else $error("check active in long mode");
  req_pair_a: assert property (buffer_request_out |-> micro_request_interrupt)
    else $error("buffer request without micro request");
  req_drop_a: assert property (buffer_request_out && buffer_ready_in |=> !buffer_request_out)
    else $error("buffer request kept after buffer ready");
  done_irq_a: assert property ($rose(disk_command_done) |-> micro_interrupt_out)
    else $error("completion without interrupt");
  done_hold_a: assert property (disk_command_done && !clear_command_done |=> disk_command_done)
    else $error("completion dropped before clear");
endmodule : dcd_props

bind dcd_read_sector dcd_props dcd_props_i (.*);

//--- verif/dcd_drive_model.sv
`timescale 1ns/10ps
module dcd_drive_model
  import dcd_pkg::*;
(
  // bench controls
  input wire logic core_clk, bad_id, ignore_sector_number,
  input wire logic [11:0] sector_bytes,
  // controller side
  input wire logic buffer_request_out, disk_data_ready, disk_command_done,
  input wire dcd_opt_type options,
  input wire logic [2:0] ext_bytes,
  input wire logic [7:0] sector_number,
  input wire logic [15:0] cylinder_in,
  input wire logic [3:0] head_in,
  // drive and micro answers
  output logic buffer_ready_in = 0, clear_request_interrupt = 0, index_pulse = 0, id_valid = 0,
  output logic data_field_mark = 0, disk_byte_valid = 0, data_check_done = 0,
  output dcd_id_type id_field = '0,
  output logic [7:0] disk_byte = 8'h00
);
  int n, total;
  task automatic tick; @(posedge core_clk); #1; endtask : tick
  always begin
    @(posedge core_clk iff buffer_request_out);
    repeat (3) tick(); // slow pointer reload
    buffer_ready_in = 1; clear_request_interrupt = 1;
    tick();
    buffer_ready_in = 0; clear_request_interrupt = 0;
    do begin
      tick(); id_valid = 1;
      id_field = '{cylinder_in, head_in, sector_number + {7'h00, bad_id | ignore_sector_number},
                   1'b0, 1'b0, 1'b1};
      tick(); id_valid = 0; id_field = ~id_field;
      if (bad_id) begin tick(); index_pulse = 1; tick(); index_pulse = 0; end
    end while (bad_id && !disk_command_done);
    if (!bad_id) begin
      tick(); data_field_mark = 1; tick(); data_field_mark = 0;
      total = sector_bytes + (options.long_mode ? ext_bytes : 0);
      n = 0; disk_byte_valid = 1; disk_byte = 8'h00;
      while (n < total) begin
        @(posedge core_clk);
        if (disk_data_ready) n++;
        #1 disk_byte = n[7:0];
      end
      disk_byte_valid = 0; disk_byte = ~disk_byte;
      repeat (4) tick();
      if (!options.long_mode) begin data_check_done = 1; tick(); data_check_done = 0; end
    end
  end
endmodule : dcd_drive_model

//--- verif/tb.sv
`timescale 1ns/10ps
module tb;
  import dcd_pkg::*;
  logic core_clk = 0, reset = 1, command_strobe = 0, command_from_host = 0, bad_id = 0;
  logic drive_ready = 1, drive_write_fault = 0, clear_command_done = 0, buffer_write_ready = 0;
  logic ignore_sector_number = 1, disk_request_disable = 0, data_mark_missing = 0;
  logic data_check_error = 0;
  logic [7:0] command_byte = 8'h00, sector_number_in = 8'h05, sector_count_in = 8'h02;
  logic [15:0] cylinder_in = 16'h0123;
  logic [3:0] head_in = 4'h2;
  logic [1:0] size_code_in = 2'd3;
  logic [11:0] sector_bytes = SIZE_CODE3;
  logic command_refused, command_start, sector_pulse_mode, relocation_found_flag, disk_data_ready;
  logic check_enable, read_gate_out, buffer_write_valid, buffer_request_out, buffer_ready_in;
  logic micro_request_interrupt, disk_command_done, micro_interrupt_out, clear_request_interrupt;
  logic index_pulse, id_valid, data_field_mark, disk_byte_valid, data_check_done;
  dcd_cmd_type command_kind;
  dcd_opt_type options;
  dcd_param_type params;
  dcd_err_type errors;
  dcd_id_type id_field;
  logic [2:0] ext_bytes, head_select_bits;
  logic [4:0] correction_span;
  logic [7:0] sector_number, alt_sector_number, reloc_bad_sector, reloc_sector;
  logic [7:0] buffer_write_data, disk_byte;
  logic [8:0] sector_count;
  logic [15:0] reloc_cylinder;
  logic [3:0] reloc_head;
  int fail_count = 0, n_compared = 0, drained = 0, per = 128, t;
  logic [7:0] code_t[11] = '{8'h30, 8'h61, 8'h40, 8'hb0, 8'h51, 8'hd1, 8'h08, 8'h00, 8'h88,
    8'h98, 8'ha1};
  dcd_cmd_type kind_t[11] = '{CMD_WRITE_SECTOR, CMD_READ_NEXT, CMD_SCAN_ID, CMD_WRITE_ID,
    CMD_FORMAT_TRACK, CMD_FORMAT_SECTOR, CMD_COMPUTE_CORR, CMD_SET_PARAM, CMD_LOAD_PARAM,
    CMD_SLEEP, CMD_DUMP};
  logic host_t[11] = '{1, 0, 0, 0, 1, 1, 0, 1, 0, 0, 0};
  logic [7:0] par_t[4] = '{8'h96, 8'h07, 8'h01, 8'h00};

  dcd_read_sector dcd_read_sector_i (.*);
  dcd_drive_model dcd_drive_model_i (.*);

  always #2.5 core_clk = ~core_clk;

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk(input logic [11:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // drain side stalls every other cycle
  always @(posedge core_clk) begin
    if (buffer_write_valid && buffer_write_ready) begin
      chk(buffer_write_data, 12'(drained % per));
      drained++;
    end
    #1 buffer_write_ready = ~buffer_write_ready;
  end

  task automatic issue(input logic [7:0] code, input logic host);
    @(posedge core_clk); #1;
    command_byte = code; command_from_host = host; command_strobe = 1;
    @(posedge core_clk); #1 command_strobe = 0;
  endtask : issue

  task automatic run(input logic [7:0] code, input logic [11:0] nb, a, s);
    drained = 0;
    issue(code, 0);
    for (t = 0; t < 20000 && disk_command_done !== 1'b1; t++) @(posedge core_clk);
    #1 if (disk_command_done !== 1'b1) begin
      fail_count++;
      $display("FAIL %0t no completion", $time);
      results();
    end
    repeat (40) @(posedge core_clk);
    #1 chk(drained, nb);
    chk(alt_sector_number, a);
    chk(sector_number, s);
    clear_command_done = 1;
    @(posedge core_clk); #1 clear_command_done = 0;
    $display("read test %h done", code);
  endtask : run

  initial begin
    repeat (5) @(posedge core_clk);
    #1 reset = 0;
    foreach (code_t[i]) begin
      issue(code_t[i], 0);
      chk(command_start, 1);
      chk(command_kind, kind_t[i]);
      issue(code_t[i], 1);
      chk(command_refused, !host_t[i]);
    end
    $display("decode test done");
    foreach (par_t[i]) begin
      issue(par_t[i], 1);
      @(posedge core_clk); #1;
      chk(ext_bytes, par_t[i][2] ? EXT_BYTES_LONG : EXT_BYTES_SHORT);
      chk(head_select_bits, par_t[i][1] ? HEAD_BITS_WIDE : HEAD_BITS_NARROW);
      chk(correction_span, par_t[i][2] ? (par_t[i][0] ? SPAN_7_WIDE : SPAN_7_NARROW)
        : (par_t[i][0] ? SPAN_4_WIDE : SPAN_4_NARROW));
    end
    issue(8'h8d, 0);
    @(posedge core_clk); #1 chk(sector_pulse_mode, 1);
    chk(params.sector_size, cylinder_in[11:0]);
    issue(8'h88, 0);
    @(posedge core_clk); #1 chk(sector_pulse_mode, 0);
    $display("parameter test done");
    run(8'h20, 12'd128, 12'h05, 12'h05);
    ignore_sector_number = 0;
    per = 132;
    run(8'h26, 12'd264, 12'h06, 12'h07);
    chk(sector_count, 0);
    bad_id = 1;
    run(8'h21, 12'd0, 12'hff, 12'h05);
    chk(errors.id_not_found, 1);
    bad_id = 0;
    drive_ready = 0;
    run(8'h20, 12'd0, 12'hff, 12'h05);
    chk(errors.aborted, 1);
    results();
  end
endmodule : tb
